// ---- core/i2cm_map.svh ----
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH
`define I2CM_PAT_DEPTH      92
`define I2CM_STEP_DIV       100
`define I2CM_DEGLITCH_CYC   8
`define I2CM_REF_RESET      8'ha5
`define I2CM_IDLE_BYTE      8'h05
`define I2CM_SLOT_BITS      9
`define I2CM_CH_SCL         0
`define I2CM_CH_ACK         1
`define I2CM_CH_SEL_LO      2
`define I2CM_CH_SEL_HI      3
`define I2CM_CH_SDA0        4
`define I2CM_CH_RDCMP       5
`define I2CM_CH_LAST        7
`endif

// ---- core/i2cm_pkg.sv ----
package i2cm_pkg;
  typedef enum logic [1:0] {
    I2CM_IDLE = 2'b00,
    I2CM_RUN  = 2'b01,
    I2CM_HALT = 2'b10,
    I2CM_DONE = 2'b11
  } i2cm_state_e;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cm_bus_s;
  typedef struct packed {
    logic ack_fail;
    logic cmp_ok;
    logic busy;
  } i2cm_stat_s;
endpackage

// ---- core/i2cm_master.sv ----
// Function
// R1: sample acknowledge on each ninth SCL clock
// R2: missing acknowledge halts the pattern transfer
// R3: two selects pick SDA pattern channel
// R4: deglitched trigger launches the command
// R5: counter divider steps the pattern sequencer
// R6: read bits checked against preloaded reference
// R7: shift reference each compare clock, compare
// R8: flop holds compare result until next read
// R9: write sends one or several bytes
// R10: one pattern byte per step, 92 max
// R11: wrap mode repeats, else hold last
// R12: open-drain SDA and SCL drive
// R13: slave drives SDA stable while SCL high
`timescale 1ns/10ps
`default_nettype none
`include "i2cm_map.svh"
module i2cm_master #(
  parameter int PAT_DEPTH = `I2CM_PAT_DEPTH,
  parameter int STEP_DIV  = `I2CM_STEP_DIV,
  parameter int DGL_CYC   = `I2CM_DEGLITCH_CYC
) (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  // control
  input  wire logic               i_trigger,
  input  wire logic               i_wrap_mode,
  input  wire logic               i_read_cmd,
  input  wire logic [6:0]         i_pat_len,
  input  wire logic [7:0]         i_ref_load,
  // pattern memory write port
  input  wire logic               i_pat_we,
  input  wire logic [6:0]         i_pat_addr,
  input  wire logic [7:0]         i_pat_data,
  // i2c pins
  input  wire logic               i_scl,
  input  wire logic               i_sda,
  output var i2cm_pkg::i2cm_bus_s o_bus,
  // status
  output var i2cm_pkg::i2cm_stat_s o_stat
);
  import i2cm_pkg::*;

  logic [7:0]  pat_mem [0:127];
  i2cm_state_e state_q;
  logic [1:0]  trig_sync_q;
  logic [1:0]  sda_sync_q;
  logic [1:0]  scl_sync_q;
  logic [7:0]  dgl_cnt_q;
  logic        trig_clean_q;
  logic        trig_prev_q;
  logic [15:0] div_cnt_q;
  logic        step_en;
  logic [6:0]  addr_q;
  logic [7:0]  byte_q;
  logic [7:0]  ref_q;
  logic        cmp_ok_q;
  logic        ack_fail_q;
  logic        scl_prev_q;
  logic        scl_rise;
  logic        launch;
  logic [1:0]  sel;
  logic        sda_bit;
  logic        last_addr;
  logic        pat_wrap;
  logic [3:0]  scl_cnt_q;
  logic        ack_slot_q;

  function automatic logic [1:0] sel_of(input logic [7:0] b);
    sel_of = {b[`I2CM_CH_SEL_HI], b[`I2CM_CH_SEL_LO]};
  endfunction

  // pattern memory load
  always_ff @(posedge i_ref_clk) begin
    if (i_pat_we) begin
      pat_mem[i_pat_addr] <= i_pat_data;
    end
  end

  // input synchronisers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      trig_sync_q <= 2'h0;
      sda_sync_q  <= 2'h3;
      scl_sync_q  <= 2'h3;
    end else begin
      trig_sync_q <= {trig_sync_q[0], i_trigger};
      sda_sync_q  <= {sda_sync_q[0], i_sda};
      scl_sync_q  <= {scl_sync_q[0], i_scl};
    end
  end

  // trigger deglitch counter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dgl_cnt_q    <= 8'h0;
      trig_clean_q <= 1'b0;
      trig_prev_q  <= 1'b0;
    end else begin
      trig_prev_q <= trig_clean_q;
      if (trig_sync_q[1] == trig_clean_q) begin
        dgl_cnt_q <= 8'h0;
      end else if (dgl_cnt_q == 8'(DGL_CYC - 1)) begin
        trig_clean_q <= trig_sync_q[1]; // R4
        dgl_cnt_q    <= 8'h0;
      end else begin
        dgl_cnt_q <= dgl_cnt_q + 8'h1;
      end
    end
  end
  assign launch = trig_clean_q && !trig_prev_q && (state_q != I2CM_RUN); // R4

  // step clock counter and logic
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_q <= 16'h0;
    end else if (div_cnt_q == 16'(STEP_DIV - 1)) begin
      div_cnt_q <= 16'h0; // R5
    end else begin
      div_cnt_q <= div_cnt_q + 16'h1;
    end
  end
  assign step_en = (div_cnt_q == 16'(STEP_DIV - 1)); // R5

  assign last_addr = (addr_q == (i_pat_len - 7'h1)) || (addr_q == 7'(PAT_DEPTH - 1));
  // pattern restarts from its first byte in wrap mode
  assign pat_wrap  = (state_q == I2CM_RUN) && step_en && last_addr && i_wrap_mode;

  // sequencer state and byte output
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= I2CM_IDLE;
      addr_q  <= 7'h0;
      byte_q  <= `I2CM_IDLE_BYTE; // lines released, no ack slot flagged
    end else begin
      case (state_q)
        I2CM_IDLE, I2CM_HALT, I2CM_DONE: begin
          if (launch) begin
            state_q <= I2CM_RUN;
            addr_q  <= 7'h0;
          end
        end
        I2CM_RUN: begin
          if (ack_slot_q && step_en && sda_sync_q[1]) begin
            state_q <= I2CM_HALT; // R2
            byte_q  <= `I2CM_IDLE_BYTE; // stale ack slot would halt next launch
          end else if (step_en) begin
            byte_q <= pat_mem[addr_q]; // R10 R9
            if (last_addr) begin
              if (i_wrap_mode) begin
                addr_q <= 7'h0; // R11
              end else begin
                state_q <= I2CM_DONE; // R11
              end
            end else begin
              addr_q <= addr_q + 7'h1;
            end
          end
        end
        default: state_q <= I2CM_IDLE;
      endcase
    end
  end

  // scl edge detect for compare and ack count
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_sync_q[1];
    end
  end
  assign scl_rise = scl_sync_q[1] && !scl_prev_q;

  // ninth clock counter, ack slot flag
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_cnt_q  <= 4'h0;
      ack_slot_q <= 1'b0;
    end else if (launch) begin
      scl_cnt_q  <= 4'h0;
      ack_slot_q <= 1'b0;
    end else begin
      ack_slot_q <= byte_q[`I2CM_CH_ACK] && byte_q[`I2CM_CH_SCL] && (state_q == I2CM_RUN); // R1
      if (pat_wrap) begin
        scl_cnt_q <= 4'h0; // R1
      end else if (scl_rise) begin
        scl_cnt_q <= (scl_cnt_q == 4'(`I2CM_SLOT_BITS - 1)) ? 4'h0 : scl_cnt_q + 4'h1; // R1
      end
    end
  end

  // ack failure flag
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_fail_q <= 1'b0;
    end else if (state_q == I2CM_RUN && ack_slot_q && step_en && sda_sync_q[1]) begin
      ack_fail_q <= 1'b1; // R2
    end else if (launch) begin
      ack_fail_q <= 1'b0;
    end
  end

  // reference shift and compare result
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_q    <= `I2CM_REF_RESET;
      cmp_ok_q <= 1'b0;
    end else if (launch && i_read_cmd) begin
      ref_q    <= i_ref_load; // R6
      cmp_ok_q <= 1'b1; // R8
    end else if (state_q == I2CM_RUN && byte_q[`I2CM_CH_RDCMP] && scl_rise) begin
      ref_q <= {ref_q[6:0], ref_q[7]}; // R7
      if (ref_q[7] != sda_sync_q[1]) begin
        cmp_ok_q <= 1'b0; // R7 R8
      end
    end
  end

  // sda source selector
  assign sel = sel_of(byte_q); // R3
  always_comb begin
    case (sel)
      2'h0:    sda_bit = byte_q[`I2CM_CH_SDA0]; // R3
      2'h1:    sda_bit = 1'b1;
      2'h2:    sda_bit = 1'b0;
      2'h3:    sda_bit = byte_q[`I2CM_CH_LAST];
      default: sda_bit = 1'b1;
    endcase
  end

  // open-drain pin drive
  assign o_bus = '{
    scl_o:  1'b0,
    scl_oe: (state_q == I2CM_RUN) && !byte_q[`I2CM_CH_SCL], // R12
    sda_o:  1'b0,
    sda_oe: (state_q == I2CM_RUN) && !sda_bit && !byte_q[`I2CM_CH_ACK] // R12 R13
  };
  // ack_fail and cmp_ok straight from their registers, busy decoded from state_q
  assign o_stat = '{
    ack_fail: ack_fail_q,
    cmp_ok:   cmp_ok_q,
    busy:     (state_q == I2CM_RUN)
  };

  AST_HALT_ON_NACK: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
    (state_q == I2CM_RUN && ack_slot_q && step_en && sda_sync_q[1]) |=> state_q == I2CM_HALT)
    else $error("nack did not halt");
  AST_FAIL_FLAG: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
    $rose(ack_fail_q) |-> state_q == I2CM_HALT)
    else $error("ack fail without halt");
  AST_ACK_NINTH: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
    (ack_slot_q && scl_rise) |-> scl_cnt_q == 4'(`I2CM_SLOT_BITS - 1))
    else $error("ack slot not on ninth clock");
  AST_STEP_PERIOD: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    step_en |=> !step_en)
    else $error("step enable too long");
  AST_LAUNCH_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
    (launch && state_q != I2CM_RUN) |=> state_q == I2CM_RUN && addr_q == 7'h0)
    else $error("launch not started");
  AST_REF_SHIFT: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
    (state_q == I2CM_RUN && byte_q[5] && scl_rise && !launch) |=> ref_q == {$past(ref_q[6:0]), $past(ref_q[7])})
    else $error("reference did not rotate");
  AST_CMP_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
    (state_q != I2CM_RUN && !launch) |=> $stable(cmp_ok_q))
    else $error("compare result changed");
  AST_SEL_PATH: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
    (state_q == I2CM_RUN && sel == 2'h2 && !byte_q[1]) |-> o_bus.sda_oe)
    else $error("selected low not driven");
  AST_OD_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
    state_q != I2CM_RUN |-> !o_bus.scl_oe && !o_bus.sda_oe)
    else $error("pins driven while idle");
  AST_HOLD_LAST: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
    (state_q == I2CM_RUN && step_en && last_addr && !i_wrap_mode && !(ack_slot_q && sda_sync_q[1]))
    |=> state_q == I2CM_DONE)
    else $error("stop mode did not hold");
endmodule
`default_nettype wire

// ---- sim/i2cm_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
// behavioural i2c slave: acks, captures bytes, returns one byte
module i2cm_slave (
  // bus levels
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  // behaviour
  input  wire logic       i_ack_en,
  input  wire logic [7:0] i_rd_data,
  // results
  output logic            o_sda_oe,
  output logic [7:0]      o_first,
  output logic [7:0]      o_last
);
  int         bit_n = 0;
  int         byte_n = 0;
  logic [7:0] sh = 8'h00;
  logic       rd = 1'b0;
  // idle: sda released to the pull-up
  initial begin
    o_sda_oe = 1'b0;
    o_first = 8'h00;
    o_last = 8'h00;
  end
  // start: sda falls while scl stays high (delay rejects a coincident scl fall)
  always @(negedge i_sda) #1 if (i_scl) begin
    bit_n = 0;
    byte_n = 0;
    rd = 1'b0;
  end
  // sample on scl rise, latch whole bytes
  always @(posedge i_scl) begin
    if (bit_n < 8) sh = {sh[6:0], i_sda};
    bit_n++;
    if (bit_n == 8 && byte_n == 0) begin
      o_first = sh;
      rd = sh[0];
    end else if (bit_n == 8) o_last = sh;
  end
  // sda changes only while scl is low
  always @(negedge i_scl) begin
    if (bit_n == 9) begin
      bit_n = 0;
      byte_n++;
    end
    if (bit_n == 8) o_sda_oe = i_ack_en && (byte_n == 0 || !rd);
    else o_sda_oe = rd && byte_n == 1 && bit_n < 8 && !i_rd_data[7 - bit_n];
  end
endmodule
`default_nettype wire

// ---- sim/i2cm_master_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2cm_master_test;
  import i2cm_pkg::*;
  logic       clk = 0, rst = 1, trg = 0, wrap = 0, rd = 0, we = 0, ack_en = 1, s_oe;
  logic [6:0] pa = 0, len = 0;
  logic [7:0] pd = 0, rref = 0, sdat = 0, s_first, s_last;
  i2cm_bus_s  bus;
  i2cm_stat_s st;
  int         errors = 0, check_count = 0;
  // open-drain wires with pull-ups
  wire logic  scl_w = ~bus.scl_oe;
  wire logic  sda_w = ~(bus.sda_oe | s_oe);
  always #2.5 clk = ~clk;
  i2cm_master #(.STEP_DIV(4), .DGL_CYC(2)) i2cm_master_inst (.i_ref_clk(clk), .i_rst(rst), .i_trigger(trg),
    .i_wrap_mode(wrap), .i_read_cmd(rd), .i_pat_len(len), .i_ref_load(rref), .i_pat_we(we), .i_pat_addr(pa),
    .i_pat_data(pd), .i_scl(scl_w), .i_sda(sda_w), .o_bus(bus), .o_stat(st));
  i2cm_slave i2cm_slave_inst (.i_scl(scl_w), .i_sda(sda_w), .i_ack_en(ack_en), .i_rd_data(sdat),
    .o_sda_oe(s_oe), .o_first(s_first), .o_last(s_last));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task put(input logic [7:0] b);
    @(negedge clk);
    we = 1;
    pd = b;
    @(negedge clk);
    we = 0;
    pa = pa + 7'h01;
  endtask
  // one scl clock: low byte then high byte
  task pbit(input logic [7:0] b);
    put(b);
    put(b | 8'h01);
  endtask
  // start, address, n bytes, stop
  task build(input logic r, input logic [7:0] w, input int n);
    logic [7:0] a;
    a = {7'h2a, r};
    pa = 0;
    put(8'h05);
    put(8'h09);
    for (int i = 7; i >= 0; i--) pbit({3'b000, a[i], 4'h0});
    pbit(8'h06);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) pbit(r ? 8'h24 : {w[i], 7'h0c});
      pbit(r ? 8'h04 : 8'h06);
      w = w + 8'h01;
    end
    put(8'h08);
    put(8'h09);
    put(8'h05);
    len = pa;
  endtask
  task pulse(input int n);
    trg = 1;
    repeat (n) @(negedge clk);
    trg = 0;
    repeat (2) @(negedge clk);
  endtask
  task run(input logic r, input logic [7:0] w, input int n);
    build(r, w, n);
    rd = r;
    pulse(10);
    for (int i = 0; i < 600 && st.busy !== 1'b0; i++) @(negedge clk);
    chk("busy end", 8'h00, st.busy);
  endtask
  task t_glitch;
    pulse(1);
    repeat (20) @(negedge clk);
    chk("glitch", 8'h00, st.busy);
  endtask
  task t_write;
    run(0, 8'hc3, 3);
    chk("addr", 8'h54, s_first);
    chk("wdata", 8'hc5, s_last);
    chk("ackfail", 8'h00, st.ack_fail);
    chk("oe", 8'h00, {bus.scl_oe, bus.sda_oe});
    chk("od", 8'h00, {bus.scl_o, bus.sda_o});
  endtask
  task t_nack;
    ack_en = 0;
    run(0, 8'h3c, 1);
    chk("nack", 8'h01, st.ack_fail);
    chk("halted", 8'hc5, s_last);
    chk("released", 8'h00, {bus.scl_oe, bus.sda_oe});
    ack_en = 1;
  endtask
  task t_read;
    rref = 8'h96;
    sdat = 8'h96;
    run(1, 8'h00, 1);
    chk("cmp", 8'h01, st.cmp_ok);
    chk("ackclr", 8'h00, st.ack_fail);
    run(0, 8'h11, 1);
    chk("cmp held", 8'h01, st.cmp_ok);
    sdat = 8'h97;
    run(1, 8'h00, 1);
    chk("cmp bad", 8'h00, st.cmp_ok);
  endtask
  task t_wrap;
    time t0;
    wrap = 1;
    build(0, 8'h01, 1);
    rd = 0;
    pulse(10);
    @(posedge scl_w);
    t0 = $time;
    @(posedge scl_w);
    chk("step", 8'h08, 8'(($time - t0) / 5));
    repeat (400) @(negedge clk);
    chk("wrap busy", 8'h01, st.busy);
    wrap = 0;
    for (int i = 0; i < 600 && st.busy !== 1'b0; i++) @(negedge clk);
    chk("stop busy", 8'h00, st.busy);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    t_glitch();
    t_write();
    t_nack();
    t_read();
    t_wrap();
    test_done();
  end
  // watchdog
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
